/* File: verilog/sbg_baud_gen.sv */
`timescale 1ns/1ps
module sbg_baud_gen
  import sbg_pkg::*;
#(
  parameter int FIXED_DIV = SBG_FIXED_DIV
)
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset_n,
  // Port clock enable from the power manager.
  input wire logic port_clk_en,
  // Configuration fields.
  input wire sbg_cfg_s cfg,
  // Serial clock pin.
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  // Clock ticks to receiver and transmitter.
  output sbg_ticks_s ticks,
  // Status.
  output logic gen_active
);

  localparam int PRE_W = (FIXED_DIV > 1) ? $clog2(FIXED_DIV) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(FIXED_DIV - 1);

  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic sck_rise;
  logic [PRE_W-1:0] pre_reg;
  logic [PRE_W-1:0] pre_next;
  logic src_tick;
  logic ext_direct;
  logic frac_on;
  logic [3:0] acc_sum;
  logic stretch;
  logic [15:0] last_cnt;
  logic [15:0] half_cnt;
  logic [15:0] div_cnt_reg;
  logic [15:0] div_cnt_next;
  logic [2:0] frac_reg;
  logic [2:0] frac_next;
  logic div_tick;
  logic [3:0] os_reg;
  logic [3:0] os_next;
  logic baud_tick;
  logic sample_reg;
  logic baud_reg;
  logic sck_hi_reg;
  logic sck_hi_next;
  logic sck_neg_reg;
  logic active_reg;
  logic odd_trim;

  // Reset is released through two flip-flops.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Pin clock edges, valid only while the pin obeys its phase and ratio limits.
  sbg_edge_sync u_sck_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .pin_in(sck_in),
    .level(),
    .rise(sck_rise),
    .fall()
  );

  // Fixed prescaler and source tick selection; nothing moves while the port clock is off.
  always_comb begin
    pre_next = pre_reg;
    if (port_clk_en) begin
      pre_next = (pre_reg == PRE_LAST) ? '0 : pre_reg + 1'b1;
    end
    case (cfg.clock_source_select)
      SBG_SRC_PERIPH: src_tick = port_clk_en;
      SBG_SRC_DIV: src_tick = port_clk_en && (pre_reg == PRE_LAST);
      SBG_SRC_EXT: src_tick = port_clk_en && sck_rise;
      default: src_tick = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_next;
    end
  end

  // Fractional stretch: one extra source tick on each carry of the eighths accumulator.
  assign ext_direct = cfg.sync_mode && (cfg.clock_source_select == SBG_SRC_EXT);
  assign frac_on = (cfg.fraction_field != 3'h0) && !cfg.sync_mode && (cfg.port_mode == SBG_MODE_NORMAL);
  assign acc_sum = {1'b0, frac_reg} + {1'b0, cfg.fraction_field};
  assign stretch = frac_on && acc_sum[3];
  assign last_cnt = stretch ? cfg.divisor_field : cfg.divisor_field - 16'h0001;
  assign half_cnt = 16'((17'(cfg.divisor_field) + 17'h00001) >> 1);

  // Divisor counter.
  always_comb begin
    div_cnt_next = div_cnt_reg;
    frac_next = frac_reg;
    div_tick = 1'b0;
    if (ext_direct) begin
      div_tick = src_tick;
      div_cnt_next = SBG_CNT_RST;
    end else if (cfg.divisor_field == SBG_CD_OFF) begin
      div_cnt_next = SBG_CNT_RST;
      frac_next = SBG_FRAC_RST;
    end else if (cfg.divisor_field == SBG_CD_BYPASS && !frac_on) begin
      div_tick = src_tick;
      div_cnt_next = SBG_CNT_RST;
    end else if (src_tick) begin
      if (div_cnt_reg >= last_cnt) begin
        div_cnt_next = SBG_CNT_RST;
        div_tick = 1'b1;
        frac_next = frac_on ? acc_sum[2:0] : SBG_FRAC_RST;
      end else begin
        div_cnt_next = div_cnt_reg + 16'h0001;
      end
    end
  end

  // Oversampling divider: async divides the sampling clock by 8 or 16, sync passes it on.
  always_comb begin
    os_next = os_reg;
    baud_tick = 1'b0;
    if (cfg.sync_mode) begin
      os_next = SBG_OS_RST;
      baud_tick = div_tick;
    end else if (div_tick) begin
      if (os_reg >= (cfg.over ? SBG_OS8_LAST : SBG_OS16_LAST)) begin
        os_next = SBG_OS_RST;
        baud_tick = 1'b1;
      end else begin
        os_next = os_reg + 4'h1;
      end
    end
  end

  // Serial clock phase: high over the first half of each divisor period above one; a bypassed divisor toggles it on each tick.
  always_comb begin
    sck_hi_next = sck_hi_reg;
    if (ext_direct || cfg.divisor_field == SBG_CD_OFF) begin
      sck_hi_next = 1'b0;
    end else if (cfg.divisor_field == SBG_CD_BYPASS && !frac_on) begin
      sck_hi_next = div_tick ? ~sck_hi_reg : sck_hi_reg;
    end else if (src_tick) begin
      sck_hi_next = div_cnt_next < half_cnt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= SBG_CNT_RST;
      frac_reg <= SBG_FRAC_RST;
      os_reg <= SBG_OS_RST;
      sample_reg <= 1'b0;
      baud_reg <= 1'b0;
      sck_hi_reg <= 1'b0;
      active_reg <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_next;
      frac_reg <= frac_next;
      os_reg <= os_next;
      sample_reg <= div_tick;
      baud_reg <= baud_tick;
      sck_hi_reg <= sck_hi_next;
      active_reg <= ext_direct || (cfg.divisor_field != SBG_CD_OFF);
    end
  end

  // Half-cycle copy that trims the long phase of an odd divisor.
  always_ff @(negedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_neg_reg <= 1'b0;
    end else begin
      sck_neg_reg <= sck_hi_reg;
    end
  end

  // Outputs; one bit-period tick feeds both directions.
  assign odd_trim = (cfg.clock_source_select == SBG_SRC_PERIPH) && cfg.divisor_field[0] &&
                    (cfg.divisor_field != SBG_CD_BYPASS);
  assign sck_out = odd_trim ? (sck_hi_reg & sck_neg_reg) : sck_hi_reg;
  assign sck_oe = cfg.sync_mode && cfg.clk_out_en && (cfg.clock_source_select != SBG_SRC_EXT);
  assign ticks.rx_sample = sample_reg;
  assign ticks.rx_baud = baud_reg;
  assign ticks.tx_baud = baud_reg;
  assign gen_active = active_reg;

  // Checks.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic div8_hold;
  assign div8_hold = port_clk_en && cfg.sync_mode && (cfg.clock_source_select == SBG_SRC_DIV) &&
                     (cfg.divisor_field == SBG_CD_BYPASS);

  a_baud_has_sample: assert property (ticks.rx_baud |-> ticks.rx_sample)
    else $error("bit tick without sampling tick");
  a_zero_no_clock: assert property ((cfg.divisor_field == SBG_CD_OFF && !ext_direct)[*2] |-> !ticks.rx_sample)
    else $error("clock produced with zero divisor");
  a_bypass_every_tick: assert property ((port_clk_en && cfg.sync_mode && cfg.clock_source_select == SBG_SRC_PERIPH
    && cfg.divisor_field == SBG_CD_BYPASS) |=> ticks.rx_sample && ticks.tx_baud)
    else $error("bypass did not pass clock through");
  a_div8_spacing: assert property (@(posedge ref_clk) disable iff (!rst_n || !div8_hold)
    (div8_hold && ticks.rx_sample) |=> (!ticks.rx_sample)[*7] ##1 ticks.rx_sample)
    else $error("divided source not one tick in eight");
  a_os_period: assert property ((ticks.rx_baud && !$past(cfg.sync_mode)) |->
    $past(os_reg) == ($past(cfg.over) ? SBG_OS8_LAST : SBG_OS16_LAST))
    else $error("oversampling count wrong at bit tick");
  a_sync_no_os: assert property ((cfg.sync_mode && $past(cfg.sync_mode)) |-> ticks.rx_baud == ticks.rx_sample)
    else $error("oversampling applied in synchronous mode");
  a_ext_direct: assert property ((ext_direct && port_clk_en && sck_rise) |=> ticks.rx_baud)
    else $error("pin clock edge not passed directly");
  a_halt_freeze: assert property (!port_clk_en |=> $stable(div_cnt_reg) && $stable(os_reg) && !ticks.rx_sample)
    else $error("state moved while port clock stopped");

  c_async16: cover property (ticks.rx_baud && !cfg.sync_mode && !cfg.over);
  c_async8: cover property (ticks.rx_baud && !cfg.sync_mode && cfg.over);
  c_sync_ext: cover property (ext_direct && ticks.rx_baud);
  c_fraction: cover property (stretch && div_tick);

endmodule

/* File: verilog/sbg_pkg.sv */
// Notes on behaviour
// - The bit-period clock goes to both the receiver and the transmitter.
// - The source select picks the peripheral clock, the peripheral clock divided by a fixed factor, or the pin clock.
// - A 16-bit divisor from the divider register divides the selected source clock.
// - A divisor of zero stops all output clocks except in synchronous mode with the pin clock selected.
// - A divisor of one with no fraction in effect bypasses the divider so the selected clock passes undivided.
// - In asynchronous mode the divided clock is the receiver sampling clock and is divided again for the bit period.
// - In asynchronous mode the oversampling bit selects 8x sampling when set and 16x when cleared.
// - In asynchronous mode the bit rate is the selected clock over 8 times (2 minus oversampling bit) times divisor.
// - The port clock enable from the power manager gates operation, and a restart resumes exactly where it halted.
// - In synchronous mode the bit rate is the selected clock over the divisor alone.
// - In synchronous mode with the pin clock selected the pin clock is used directly and the divisor is ignored.
// - A nonzero fraction field adds eighths to the divisor in asynchronous normal mode only.
// - With the peripheral clock as source the serial clock output keeps a 50:50 duty cycle even for odd divisors.
package sbg_pkg;

  // Clock source select codes.
  localparam logic [1:0] SBG_SRC_PERIPH = 2'h0;
  localparam logic [1:0] SBG_SRC_DIV = 2'h1;
  localparam logic [1:0] SBG_SRC_EXT = 2'h3;

  // Fixed prescale factor of the divided peripheral clock source.
  localparam int SBG_FIXED_DIV = 8;

  // Port mode codes.
  localparam logic [3:0] SBG_MODE_NORMAL = 4'h0;
  localparam logic [3:0] SBG_MODE_SPI_MASTER = 4'he;
  localparam logic [3:0] SBG_MODE_SPI_SLAVE = 4'hf;

  // Last oversampling count for 16x and 8x sampling.
  localparam logic [3:0] SBG_OS16_LAST = 4'hf;
  localparam logic [3:0] SBG_OS8_LAST = 4'h7;

  // Special divisor values and counter reset values.
  localparam logic [15:0] SBG_CD_OFF = 16'h0000;
  localparam logic [15:0] SBG_CD_BYPASS = 16'h0001;
  localparam logic [15:0] SBG_CNT_RST = 16'h0000;
  localparam logic [3:0] SBG_OS_RST = 4'h0;
  localparam logic [2:0] SBG_FRAC_RST = 3'h0;

  // Fields of the port mode register and divider register that steer the generator.
  typedef struct packed {
    logic [3:0] port_mode;
    logic [1:0] clock_source_select;
    logic sync_mode;
    logic over;
    logic clk_out_en;
    logic [15:0] divisor_field;
    logic [2:0] fraction_field;
  } sbg_cfg_s;

  // Clock ticks handed to the receiver and the transmitter.
  typedef struct packed {
    logic rx_sample;
    logic rx_baud;
    logic tx_baud;
  } sbg_ticks_s;

endpackage

/* File: verilog/sbg_edge_sync.sv */
`timescale 1ns/1ps
module sbg_edge_sync
  import sbg_pkg::*;
(
  // Clock and synchronised reset.
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous pin.
  input wire logic pin_in,
  // Synchronised level and edge pulses.
  output logic level,
  output logic rise,
  output logic fall
);

  logic [2:0] sync_reg;
  logic [2:0] sync_next;

  // Two stages resolve metastability, the third holds the previous level for edge detection.
  always_comb begin
    sync_next = {sync_reg[1:0], pin_in};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_reg <= 3'h0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  // Only the second and third stages are looked at.
  assign level = sync_reg[1];
  assign rise = sync_reg[1] & ~sync_reg[2];
  assign fall = ~sync_reg[1] & sync_reg[2];

endmodule

/* File: test/sbg_sck_source.sv */
`timescale 1ns/1ps
module sbg_sck_source #(
  parameter int HALF_NS = 40
)
(
  // Run request from the bench.
  input wire logic run,
  // Pin clock towards the generator.
  output logic sck
);
  // Each phase spans several peripheral clocks, and the pin stands still low while not running.
  initial begin
    sck = 1'b0;
    #3;
    forever begin
      if (run) begin
        #HALF_NS sck = 1'b1;
        #HALF_NS sck = 1'b0;
      end else begin
        #5;
      end
    end
  end
endmodule

/* File: test/serial_baud_rate_generator_tb.sv */
`timescale 1ns/1ps
module serial_baud_rate_generator_tb;
  import sbg_pkg::*;
  localparam int FDIV = SBG_FIXED_DIV;
  localparam int PER = 8;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic port_clk_en = 1'b0;
  logic ext_run = 1'b0;
  sbg_cfg_s cfg = '0;
  logic sck_in;
  logic sck_out;
  logic sck_oe;
  sbg_ticks_s ticks;
  logic gen_active;
  int num_errors = 0;
  int num_checks = 0;
  int seed = 32'hfe02;
  int t0;
  int t1;

  // Free-running peripheral clock.
  always #5 ref_clk = ~ref_clk;

  sbg_baud_gen #(.FIXED_DIV(FDIV)) DUT (.ref_clk(ref_clk), .reset_n(reset_n), .port_clk_en(port_clk_en),
    .cfg(cfg), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .ticks(ticks), .gen_active(gen_active));
  sbg_sck_source #(.HALF_NS(PER * 5)) src_model (.run(ext_run), .sck(sck_in));

  task automatic check(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      num_errors++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Reference model: cycles taken by eight sampling periods.
  function automatic int exp_span(input logic [3:0] mode, input logic [1:0] src, input bit sync, input int cd,
                                  input int fp);
    int f;
    f = (src == SBG_SRC_PERIPH) ? 1 : (src == SBG_SRC_DIV) ? FDIV : PER;
    if (sync && src == SBG_SRC_EXT) return 8 * PER;
    if (!sync && mode == SBG_MODE_NORMAL) return f * (8 * cd + fp);
    return f * 8 * cd;
  endfunction

  task automatic step(input bit en);
    @(posedge ref_clk);
    port_clk_en <= en;
    #1;
    check(ticks.rx_baud === ticks.tx_baud, "receiver and transmitter ticks differ");
  endtask

  task automatic wait_tick(input bit baud);
    int n;
    n = 0;
    do begin
      step(1'b1);
      n++;
    end while (((baud ? ticks.rx_baud : ticks.rx_sample) !== 1'b1) && n < 5000);
    if (n >= 5000) begin
      check(1'b0, "tick timeout");
      wrap_up();
    end
  endtask

  task automatic set_cfg(input logic [3:0] mode, input logic [1:0] src, input bit sync, input bit over,
                         input int cd, input int fp);
    @(posedge ref_clk);
    cfg <= '{port_mode: mode, clock_source_select: src, sync_mode: sync, over: over, clk_out_en: 1'b1,
             divisor_field: 16'(cd), fraction_field: 3'(fp)};
    ext_run <= (src == SBG_SRC_EXT);
  endtask

  // Measures the sampling period and the samples per bit, with an optional clock stop.
  task automatic run(input logic [3:0] mode, input logic [1:0] src, input bit sync, input bit over,
                     input int cd, input int fp, input int pause);
    int cyc;
    int cnt;
    set_cfg(mode, src, sync, over, cd, fp);
    repeat (2) wait_tick(1'b0);
    cyc = 0;
    cnt = 0;
    while (cnt < 8 && cyc < 5000) begin
      step(!(cyc >= 2 && cyc < 2 + pause));
      cyc++;
      if (ticks.rx_sample === 1'b1) cnt++;
    end
    check(cyc === exp_span(mode, src, sync, cd, fp) + pause, "sampling period");
    wait_tick(1'b1);
    cnt = 0;
    cyc = 0;
    do begin
      step(1'b1);
      cyc++;
      if (ticks.rx_sample === 1'b1) cnt++;
    end while (ticks.rx_baud !== 1'b1 && cyc < 5000);
    check(cnt === (sync ? 1 : over ? 8 : 16), "samples per bit");
    check(gen_active === 1'b1, "generator idle");
    check(sck_oe === (sync && src != SBG_SRC_EXT), "serial clock enable");
  endtask

  task automatic poll(input logic v);
    for (int i = 0; i < 100 && sck_out !== v; i++) #1;
  endtask

  // Main sequence.
  initial begin
    int cnt;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    port_clk_en <= 1'b1;
    repeat (4) @(posedge ref_clk);
    run(SBG_MODE_NORMAL, SBG_SRC_PERIPH, 1'b0, 1'b0, 3, 0, 0);
    run(SBG_MODE_NORMAL, SBG_SRC_PERIPH, 1'b0, 1'b1, 1, 0, 0);
    run(SBG_MODE_NORMAL, SBG_SRC_DIV, 1'b0, 1'b0, 2, 0, 0);
    run(SBG_MODE_NORMAL, SBG_SRC_DIV, 1'b1, 1'b0, 1, 0, 0);
    run(SBG_MODE_NORMAL, SBG_SRC_PERIPH, 1'b0, 1'b1, 6, 0, 10);
    run(SBG_MODE_NORMAL, SBG_SRC_PERIPH, 1'b0, 1'b0, 5, 3, 0);
    run(SBG_MODE_SPI_MASTER, SBG_SRC_PERIPH, 1'b0, 1'b0, 4, 3, 0);
    run(SBG_MODE_NORMAL, SBG_SRC_PERIPH, 1'b1, 1'b0, 4, 3, 0);
    run(SBG_MODE_NORMAL, SBG_SRC_EXT, 1'b0, 1'b1, 2, 0, 0);
    run(SBG_MODE_SPI_SLAVE, SBG_SRC_EXT, 1'b1, 1'b0, 0, 0, 0);
    for (int i = 0; i < 3; i++) begin
      run(SBG_MODE_NORMAL, SBG_SRC_PERIPH, 1'b0, 1'($random(seed)), 2 + ($unsigned($random(seed)) % 19), 0, 0);
    end
    set_cfg(SBG_MODE_NORMAL, SBG_SRC_PERIPH, 1'b0, 1'b0, 0, 0);
    cnt = 0;
    repeat (100) begin
      step(1'b1);
      if (ticks !== '0) cnt++;
    end
    check(cnt === 0 && gen_active === 1'b0, "ticks with zero divisor");
    // The unused source code must give no clock at all.
    set_cfg(SBG_MODE_NORMAL, 2'h2, 1'b0, 1'b0, 3, 0);
    cnt = 0;
    repeat (100) begin
      step(1'b1);
      if (ticks !== '0) cnt++;
    end
    check(cnt === 0, "ticks from the unused source code");
    set_cfg(SBG_MODE_NORMAL, SBG_SRC_PERIPH, 1'b1, 1'b0, 3, 0);
    repeat (20) step(1'b1);
    #0.2;
    poll(1'b0);
    poll(1'b1);
    t0 = $time;
    poll(1'b0);
    t1 = $time;
    poll(1'b1);
    check(t1 - t0 === 15 && $time - t1 === 15, "serial clock duty");
    wrap_up();
  end

  // Cuts a hang short.
  initial begin
    #400us;
    check(1'b0, "run timeout");
    wrap_up();
  end
endmodule
